// File: hdl/wrc_regs.vh
// Register map, field positions, reset values and counts of the watchdog and reset block.
// Assumes a 32-bit APB slave at 125 MHz with word-aligned registers.
`ifndef WRC_REGS_VH
`define WRC_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define WRC_ADDR_CAUSE 8'h00
`define WRC_ADDR_OPT1 8'h04
`define WRC_ADDR_OPT2 8'h08
`define WRC_ADDR_IRQ_STAT 8'h0C
`define WRC_ADDR_IRQ_EN 8'h10
`define WRC_ADDR_IRQ_CLR 8'h14

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define WRC_CAUSE_LOW_VOLTAGE 1
`define WRC_CAUSE_CLOCK_LOSS 2
`define WRC_CAUSE_ILLEGAL_ADDRESS 3
`define WRC_CAUSE_ILLEGAL_OPCODE 4
`define WRC_CAUSE_WDOG 5
`define WRC_CAUSE_PIN 6
`define WRC_CAUSE_POR 7
`define WRC_OPT2_CLKSEL 0
`define WRC_OPT2_WINDOW 1
`define WRC_OPT1_RESET 2'h3
`define WRC_OPT2_RESET 2'h0
`define WRC_EV_SERVICED 0
`define WRC_EV_BAD_WRITE 1
`define WRC_EV_TIMEOUT 2
`define WRC_SERVICE_FIRST 32'h00000055
`define WRC_SERVICE_SECOND 32'h000000AA

// ----------------------------------------------------------------
// Timing counts in cycles
// ----------------------------------------------------------------
`define WRC_PIN_DRIVE_CYCLES 34
`define WRC_PIN_SAMPLE_CYCLES 38
`define WRC_LPO_LONGEST 1024

`endif

// File: hdl/wrc_top.v
// Watchdog timer and system reset sequencer with an APB register slave.
// Assumes a 1 kHz tick pulse from the internal oscillator, synchronous to pclk, and a
// reset pin with external pull-up whose level arrives synchronised on rst_pin_in.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "wrc_regs.vh"

module wrc_top #(
    parameter TIMEOUT_BUS_SHORT = 8192,
    parameter TIMEOUT_BUS_MID = 65536,
    parameter TIMEOUT_BUS_LONG = 262144,
    parameter TIMEOUT_LPO_SHORT = 32,
    parameter TIMEOUT_LPO_MID = 256
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire tick_1khz,
    input wire stop_mode,
    input wire debug_mode,
    input wire illegal_opcode_reset,
    input wire illegal_address_reset,
    input wire low_voltage_reset,
    input wire clock_loss_reset,
    input wire debug_forced_reset,
    input wire rst_pin_in,
    output reg rst_pin_out,
    output reg rst_pin_oe_n,
    output reg system_reset,
    output reg irq
);

    // ----------------------------------------------------------------
    // States and helpers
    // ----------------------------------------------------------------
    localparam [2:0] S_RUN = 3'b001;
    localparam [2:0] S_DRIVE = 3'b010;
    localparam [2:0] S_WAIT = 3'b100;

    function [31:0] limit_of;
        input bus_clk;
        input [1:0] sel;
        begin
            case ({bus_clk, sel})
                3'b001: limit_of = TIMEOUT_LPO_SHORT;
                3'b010: limit_of = TIMEOUT_LPO_MID;
                3'b011: limit_of = `WRC_LPO_LONGEST;
                3'b101: limit_of = TIMEOUT_BUS_SHORT;
                3'b110: limit_of = TIMEOUT_BUS_MID;
                3'b111: limit_of = TIMEOUT_BUS_LONG;
                default: limit_of = 32'h00000000;
            endcase
        end
    endfunction

    reg [2:0] state;
    reg [5:0] seq_count;
    reg [7:0] cause;
    reg [7:0] pend_cause;
    reg [1:0] timeout_sel;
    reg [1:0] opt2;
    reg opt1_locked;
    reg opt2_locked;
    reg [31:0] wd_count;
    reg first_seen;
    reg [2:0] irq_stat;
    reg [2:0] irq_en;

    wire bus_clk_sel = opt2[`WRC_OPT2_CLKSEL];
    wire [31:0] limit = limit_of(bus_clk_sel, timeout_sel);
    wire wd_enabled = (timeout_sel != 2'h0);
    wire halted = stop_mode | debug_mode;
    wire running = (state == S_RUN);

    // APB access phase completes on this edge
    wire access = psel & penable & pready;
    wire wr = access & pwrite & running;
    wire wr_cause = wr & (paddr == `WRC_ADDR_CAUSE);
    wire is_first = (pwdata == `WRC_SERVICE_FIRST);
    wire is_second = (pwdata == `WRC_SERVICE_SECOND);
    // Window open in the last quarter of the period
    wire in_window = (wd_count >= (limit - {2'h0, limit[31:2]}));
    wire window_on = opt2[`WRC_OPT2_WINDOW] & bus_clk_sel;

    wire bad_value = wr_cause & ~is_first & ~is_second;
    wire early_write = wr_cause & (is_first | is_second) & window_on & ~in_window & wd_enabled;
    wire bad_write = bad_value | early_write;
    wire serviced = wr_cause & is_second & first_seen & ~early_write;
    wire timeout = running & wd_enabled & (wd_count >= limit - 32'h00000001) &
        (bus_clk_sel ? ~halted : tick_1khz & ~halted);

    wire opt1_first = wr & (paddr == `WRC_ADDR_OPT1) & ~opt1_locked;
    wire opt2_first = wr & (paddr == `WRC_ADDR_OPT2) & ~opt2_locked;

    reg [7:0] req_cause;
    always @* begin
        req_cause = 8'h00;
        req_cause[`WRC_CAUSE_LOW_VOLTAGE] = low_voltage_reset;
        req_cause[`WRC_CAUSE_CLOCK_LOSS] = clock_loss_reset;
        req_cause[`WRC_CAUSE_ILLEGAL_ADDRESS] = illegal_address_reset;
        req_cause[`WRC_CAUSE_ILLEGAL_OPCODE] = illegal_opcode_reset;
        req_cause[`WRC_CAUSE_WDOG] = timeout | bad_write;
    end
    wire pin_request = running & ~rst_pin_in;
    wire any_request = running & ((req_cause != 8'h00) | debug_forced_reset | pin_request);

    // ----------------------------------------------------------------
    // Reset sequencer
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_DRIVE;
            seq_count <= 6'h00;
            cause <= 8'h00;
            pend_cause <= 8'h80;
            system_reset <= 1'b1;
            rst_pin_out <= 1'b0;
            rst_pin_oe_n <= 1'b0;
        end else begin
            rst_pin_out <= 1'b0;
            case (state)
                S_RUN: begin
                    if (any_request) begin
                        state <= S_DRIVE;
                        seq_count <= 6'h00;
                        pend_cause <= req_cause;
                        system_reset <= 1'b1;
                        rst_pin_oe_n <= 1'b0;
                    end
                end
                S_DRIVE: begin
                    if ({26'h0, seq_count} == `WRC_PIN_DRIVE_CYCLES - 1) begin
                        state <= S_WAIT;
                        seq_count <= 6'h00;
                        rst_pin_oe_n <= 1'b1;
                    end else begin
                        seq_count <= seq_count + 6'h01;
                    end
                end
                S_WAIT: begin
                    if ({26'h0, seq_count} == `WRC_PIN_SAMPLE_CYCLES - 1) begin
                        seq_count <= 6'h00;
                        if (rst_pin_in) begin
                            state <= S_RUN;
                            system_reset <= 1'b0;
                            cause <= pend_cause;
                        end else begin
                            pend_cause[`WRC_CAUSE_PIN] <= 1'b1;
                        end
                    end else begin
                        seq_count <= seq_count + 6'h01;
                    end
                end
                default: begin
                    state <= S_DRIVE;
                    seq_count <= 6'h00;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Watchdog options and counter
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_sel <= `WRC_OPT1_RESET;
            opt2 <= `WRC_OPT2_RESET;
            opt1_locked <= 1'b0;
            opt2_locked <= 1'b0;
            wd_count <= 32'h00000000;
            first_seen <= 1'b0;
        end else if (!running) begin
            timeout_sel <= `WRC_OPT1_RESET;
            opt2 <= `WRC_OPT2_RESET;
            opt1_locked <= 1'b0;
            opt2_locked <= 1'b0;
            wd_count <= 32'h00000000;
            first_seen <= 1'b0;
        end else begin
            if (opt1_first) begin
                timeout_sel <= pwdata[1:0];
                opt1_locked <= 1'b1;
            end
            if (opt2_first) begin
                opt2 <= pwdata[1:0];
                opt2_locked <= 1'b1;
            end
            if (wr_cause & is_first & ~early_write) begin
                first_seen <= 1'b1;
            end else if (serviced | bad_write) begin
                first_seen <= 1'b0;
            end
            if (serviced | opt1_first | opt2_first | ~wd_enabled) begin
                wd_count <= 32'h00000000;
            end else if (bus_clk_sel) begin
                if (!halted) begin
                    wd_count <= wd_count + 32'h00000001;
                end
            end else if (halted) begin
                wd_count <= 32'h00000000;
            end else if (tick_1khz) begin
                wd_count <= wd_count + 32'h00000001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt flags
    // ----------------------------------------------------------------
    wire [2:0] events = {timeout, bad_write, serviced};
    wire [2:0] clr_bits = (access & pwrite & (paddr == `WRC_ADDR_IRQ_CLR)) ? pwdata[2:0] : 3'h0;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= 3'h0;
            irq_en <= 3'h0;
            irq <= 1'b0;
        end else begin
            // Set wins over clear
            irq_stat <= (irq_stat & ~clr_bits) | events;
            if (access & pwrite & (paddr == `WRC_ADDR_IRQ_EN)) begin
                irq_en <= pwdata[2:0];
            end
            irq <= |(((irq_stat & ~clr_bits) | events) &
                ((access & pwrite & (paddr == `WRC_ADDR_IRQ_EN)) ? pwdata[2:0] : irq_en));
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    reg [31:0] next_prdata;
    reg next_err;
    always @* begin
        next_prdata = 32'h00000000;
        next_err = 1'b0;
        case (paddr)
            `WRC_ADDR_CAUSE: next_prdata = {24'h000000, cause};
            `WRC_ADDR_OPT1: next_prdata = {30'h0, timeout_sel};
            `WRC_ADDR_OPT2: next_prdata = {30'h0, opt2};
            `WRC_ADDR_IRQ_STAT: next_prdata = {29'h0, irq_stat};
            `WRC_ADDR_IRQ_EN: next_prdata = {29'h0, irq_en};
            `WRC_ADDR_IRQ_CLR: next_prdata = 32'h00000000;
            default: next_err = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            if (psel & ~penable & ~pready) begin
                pready <= 1'b1;
                pslverr <= next_err;
                prdata <= pwrite ? 32'h00000000 : next_prdata;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

endmodule // wrc_top

// File: testbench/wrc_asserts.sv
// Checker for reset sequencing and bus answers of wrc_top.
// Assumes a bind to wrc_top; sees only its ports.
`timescale 1ns/1ns
module wrc_asserts (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire low_voltage_reset,
    input wire rst_pin_in,
    input wire rst_pin_out,
    input wire rst_pin_oe_n,
    input wire system_reset
);
    reg [7:0] low_cnt;
    reg [9:0] run_cnt;
    wire acc = psel && penable && pready;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------------------------------
    // Cycle counters
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt <= 8'h00;
            run_cnt <= 10'h000;
        end else begin
            low_cnt <= rst_pin_oe_n ? 8'h00 : low_cnt + 8'h01;
            run_cnt <= system_reset ? run_cnt + 10'h001 : 10'h000;
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_pin_low_len: assert property ($rose(rst_pin_oe_n) |-> low_cnt == 8'h22)
        else $error("pin drive length wrong");
    a_pin_drive_low: assert property (!rst_pin_oe_n |-> !rst_pin_out)
        else $error("pin driven high");
    a_sample_delay: assert property ($fell(system_reset) |->
        rst_pin_in && $past(rst_pin_oe_n, 38))
        else $error("pin sampled at wrong time");
    a_run_len: assert property ($fell(system_reset) |-> run_cnt == 10'h048
        || run_cnt == 10'h06E || run_cnt == 10'h094)
        else $error("reset sequence length wrong");
    a_req_entry: assert property (low_voltage_reset && !system_reset |=>
        system_reset && !rst_pin_oe_n)
        else $error("request did not start reset");
    a_bad_write: assert property (acc && pwrite && paddr == 8'h00 && pwdata != 32'h55
        && pwdata != 32'hAA && !system_reset |-> ##[1:2] system_reset)
        else $error("bad service value ignored");
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (acc && paddr > 8'h14 |-> pslverr)
        else $error("unmapped access not refused");
    c_reset_done: cover property ($fell(system_reset));
    c_pin_held: cover property ($rose(rst_pin_oe_n) ##38 !rst_pin_in);
    c_refused: cover property (acc && pslverr);
endmodule // wrc_asserts
bind wrc_top wrc_asserts i_wrc_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .low_voltage_reset(low_voltage_reset), .rst_pin_in(rst_pin_in),
    .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .system_reset(system_reset));

// File: testbench/wrc_pin_model.sv
// Reset pin: pull-up, block pull-down, optional outside hold-low.
// Assumes the block drives only while rst_pin_oe_n is low.
`timescale 1ns/1ns
module wrc_pin_model (
    input wire rst_pin_out,
    input wire rst_pin_oe_n,
    input wire hold_low,
    output wire rst_pin_in
);
    assign rst_pin_in = (rst_pin_oe_n | rst_pin_out) & !hold_low;
endmodule // wrc_pin_model

// File: testbench/watchdog_reset_control_bench.sv
// Bench for wrc_top: APB tasks, pin model, queued read checks.
// Assumes short timeout parameters and a random 1 kHz tick.
`timescale 1ns/1ns
`include "wrc_regs.vh"
module watchdog_reset_control_bench;
    reg pclk = 1'h0;
    reg presetn = 1'h0;
    reg psel = 1'h0;
    reg penable = 1'h0;
    reg pwrite = 1'h0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg tick = 1'h0;
    reg stop_mode = 1'h0;
    reg debug_mode = 1'h0;
    reg hold = 1'h0;
    reg last_err;
    reg [4:0] req = 5'h00;
    wire [31:0] prdata;
    wire pready, pslverr, pin_in, pin_out, pin_oe_n, sys_rst, irq;
    integer errors = 0, checks = 0, cyc = 0, i, n;
    integer seed = 32'h37E9E8CA;
    logic [31:0] exp_q[$];
    logic [7:0] tab [0:4] = '{8'h10, 8'h08, 8'h02, 8'h44, 8'h00};
    wrc_top #(.TIMEOUT_BUS_SHORT(16), .TIMEOUT_BUS_MID(32), .TIMEOUT_BUS_LONG(64),
        .TIMEOUT_LPO_SHORT(4), .TIMEOUT_LPO_MID(8)) i_wrc_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tick_1khz(tick), .stop_mode(stop_mode), .debug_mode(debug_mode),
        .illegal_opcode_reset(req[0]), .illegal_address_reset(req[1]),
        .low_voltage_reset(req[2]), .clock_loss_reset(req[3]), .debug_forced_reset(req[4]),
        .rst_pin_in(pin_in), .rst_pin_out(pin_out), .rst_pin_oe_n(pin_oe_n),
        .system_reset(sys_rst), .irq(irq));
    wrc_pin_model i_wrc_pin_model (.rst_pin_out(pin_out), .rst_pin_oe_n(pin_oe_n),
        .hold_low(hold), .rst_pin_in(pin_in));
    initial forever #4 pclk = ~pclk;
    always @(posedge pclk) begin
        tick <= ($random(seed) & 3) == 0;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors = errors + 1;
            end_of_test;
        end
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task step;
        @(posedge pclk);
        n = n + 1;
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        step;
        while (pready !== 1'h1) step;
        last_err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'h0, a, 32'h0);
    endtask
    task wait_rst;
        n = 0;
        while (sys_rst !== 1'h1 && n < 100) step;
        while (sys_rst !== 1'h0 && n < 900) step;
        chk("reset_done", sys_rst, 32'h0);
        @(posedge pclk);
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge pclk)
        if (psel && penable && pready === 1'h1 && !pwrite && exp_q.size() > 0)
            chk("prdata", prdata, exp_q.pop_front());
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        wait_rst;
        rd(`WRC_ADDR_CAUSE, 32'h80);
        rd(`WRC_ADDR_OPT1, 32'h3);
        rd(`WRC_ADDR_OPT2, 32'h0);
        apb(1'h0, 8'h40, 32'h0);
        chk("pslverr", last_err, 32'h1);
        $display("test reset done");
        apb(1'h1, `WRC_ADDR_IRQ_EN, 32'h7);
        apb(1'h1, `WRC_ADDR_CAUSE, `WRC_SERVICE_FIRST);
        apb(1'h1, `WRC_ADDR_CAUSE, `WRC_SERVICE_SECOND);
        rd(`WRC_ADDR_IRQ_STAT, 32'h1);
        rd(`WRC_ADDR_CAUSE, 32'h80);
        chk("irq", irq, 32'h1);
        apb(1'h1, `WRC_ADDR_IRQ_CLR, 32'h7);
        repeat (2) @(posedge pclk);
        chk("irq", irq, 32'h0);
        $display("test service done");
        for (i = 0; i < 5; i = i + 1) begin
            hold <= (i == 3);
            req <= 5'h01 << i;
            @(posedge pclk);
            req <= 5'h00;
            if (i == 3) begin
                repeat (100) @(posedge pclk);
                hold <= 1'h0;
            end
            wait_rst;
            rd(`WRC_ADDR_CAUSE, tab[i]);
        end
        $display("test sources done");
        apb(1'h1, `WRC_ADDR_CAUSE, {$random(seed)} | 32'h100);
        wait_rst;
        rd(`WRC_ADDR_CAUSE, 32'h20);
        rd(`WRC_ADDR_IRQ_STAT, 32'h2);
        chk("irq", irq, 32'h1);
        apb(1'h1, `WRC_ADDR_IRQ_CLR, 32'h7);
        $display("test bad write done");
        apb(1'h1, `WRC_ADDR_OPT2, 32'h1);
        stop_mode <= 1'h1;
        apb(1'h1, `WRC_ADDR_OPT1, 32'h1);
        apb(1'h1, `WRC_ADDR_OPT1, 32'h3);
        repeat (40) @(posedge pclk);
        chk("stop_hold", sys_rst, 32'h0);
        stop_mode <= 1'h0;
        n = 0;
        while (sys_rst !== 1'h1 && n < 200) step;
        chk("bus_timeout", n > 10 && n < 20, 32'h1);
        wait_rst;
        rd(`WRC_ADDR_IRQ_STAT, 32'h4);
        apb(1'h1, `WRC_ADDR_IRQ_CLR, 32'h7);
        $display("test timeout done");
        apb(1'h1, `WRC_ADDR_OPT2, 32'h3);
        repeat (48) @(posedge pclk);
        apb(1'h1, `WRC_ADDR_CAUSE, `WRC_SERVICE_FIRST);
        apb(1'h1, `WRC_ADDR_CAUSE, `WRC_SERVICE_SECOND);
        apb(1'h1, `WRC_ADDR_CAUSE, `WRC_SERVICE_FIRST);
        wait_rst;
        rd(`WRC_ADDR_IRQ_STAT, 32'h3);
        apb(1'h1, `WRC_ADDR_IRQ_CLR, 32'h7);
        $display("test window done");
        apb(1'h1, `WRC_ADDR_OPT2, 32'h2);
        apb(1'h1, `WRC_ADDR_CAUSE, `WRC_SERVICE_FIRST);
        apb(1'h1, `WRC_ADDR_CAUSE, `WRC_SERVICE_SECOND);
        rd(`WRC_ADDR_IRQ_STAT, 32'h1);
        debug_mode <= 1'h1;
        apb(1'h1, `WRC_ADDR_OPT1, 32'h1);
        repeat (60) @(posedge pclk);
        chk("debug_clear", sys_rst, 32'h0);
        debug_mode <= 1'h0;
        wait_rst;
        rd(`WRC_ADDR_CAUSE, 32'h20);
        $display("test slow clock done");
        end_of_test;
    end
endmodule // watchdog_reset_control_bench
